// *** rtl/tpo_option_ctl.sv ***
// option register with timer clock select and shared prescaler
`timescale 1ns/1ps
module tpo_option_ctl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins and neighbours
  input wire logic timer_ext_clock_pin_i,
  input wire logic ext_interrupt_pin_i,
  input wire logic watchdog_tick_i,
  output logic [7:0] port_b_pullup_en_o,
  output logic weak_pullup_disable_o,
  output logic ext_int_event_o,
  output logic timer_inc_o,
  output logic watchdog_tick_o
);
  typedef struct packed {
    logic [7:0] cfg;
    logic ack;
    logic [31:0] dat;
    logic tpin_prev;
    logic ipin_prev;
    logic int_evt;
    logic timer_inc;
    logic wdt_tick;
    logic pre_clear;
    logic [2:0] settle;
  } tpo_ctl_s;

  tpo_ctl_s s_q;
  tpo_ctl_s s_d;

  logic tpin_lvl;
  logic ipin_lvl;
  logic src_tick;
  logic pre_in;
  logic pre_out;
  logic [3:0] pre_shift;
  logic [2:0] ratio;
  logic assign_wdt;
  logic hit_cfg;
  logic hit_stat;
  logic req;
  logic [7:0] new_cfg;
  logic [7:0] status;
  logic pins_ready;

  tpo_pin_sync u_tpin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(timer_ext_clock_pin_i),
    .level_o(tpin_lvl)
  );

  tpo_pin_sync u_ipin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(ext_interrupt_pin_i),
    .level_o(ipin_lvl)
  );

  assign ratio = s_q.cfg[tpo_pkg::TPO_RATIO_LSB +: tpo_pkg::TPO_RATIO_W];
  assign assign_wdt = s_q.cfg[tpo_pkg::TPO_ASSIGN_BIT];
  // a pin already high at reset must not look like a fresh edge
  assign pins_ready = (s_q.settle == 3'h0);

  // timer count source: every cycle or the chosen pin edge
  always_comb begin
    if (s_q.cfg[tpo_pkg::TPO_CLK_SRC_BIT]) begin
      if (s_q.cfg[tpo_pkg::TPO_CLK_EDGE_BIT]) begin
        src_tick = pins_ready & s_q.tpin_prev & ~tpin_lvl;
      end else begin
        src_tick = pins_ready & ~s_q.tpin_prev & tpin_lvl;
      end
    end else begin
      src_tick = 1'b1;
    end
  end

  // one divider, fed from whichever side owns it
  always_comb begin
    if (assign_wdt) begin
      pre_in = watchdog_tick_i;
      pre_shift = {1'b0, ratio};
    end else begin
      pre_in = src_tick;
      pre_shift = {1'b0, ratio} + 4'h1;
    end
  end

  tpo_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(s_q.pre_clear),
    .tick_i(pre_in),
    .shift_i(pre_shift),
    .tick_o(pre_out)
  );

  assign req = cyc_i & stb_i & ~s_q.ack;
  assign hit_cfg = (adr_i[31:14] == 18'h00000) && (adr_i[13:2] == tpo_pkg::TPO_CFG_IDX);
  assign hit_stat = (adr_i[31:14] == 18'h00000) && (adr_i[13:2] == tpo_pkg::TPO_STAT_IDX);
  assign new_cfg = dat_i[7:0];

  always_comb begin
    status = 8'h00;
    status[tpo_pkg::TPO_ST_TPIN_BIT] = tpin_lvl;
    status[tpo_pkg::TPO_ST_IPIN_BIT] = ipin_lvl;
    status[tpo_pkg::TPO_ST_ASSIGN_BIT] = assign_wdt;
  end

  always_comb begin
    s_d = s_q;
    s_d.tpin_prev = tpin_lvl;
    s_d.ipin_prev = ipin_lvl;
    s_d.pre_clear = 1'b0;
    if (!pins_ready) begin
      s_d.settle = s_q.settle - 3'h1;
    end
    // interrupt pin edge detect on the synchronised level
    if (s_q.cfg[tpo_pkg::TPO_INT_EDGE_BIT]) begin
      s_d.int_evt = pins_ready & ~s_q.ipin_prev & ipin_lvl;
    end else begin
      s_d.int_evt = pins_ready & s_q.ipin_prev & ~ipin_lvl;
    end
    // with the divider on the watchdog the timer counts undivided
    s_d.timer_inc = assign_wdt ? src_tick : pre_out;
    s_d.wdt_tick = assign_wdt ? pre_out : watchdog_tick_i;
    // bus: one wait state, ack dropped the cycle after it was given
    s_d.ack = req;
    if (req) begin
      s_d.dat = 32'h0000_0000;
      if (hit_cfg) begin
        s_d.dat = {24'h00_0000, s_q.cfg};
        if (we_i && sel_i[0]) begin
          s_d.cfg = new_cfg;
          // divider count clears the cycle after any reassignment, but a wrap on the edge the
          // write is taken still passes one stray tick to the new owner; software still owns the sequence
          if (new_cfg[tpo_pkg::TPO_ASSIGN_BIT] != assign_wdt) begin
            s_d.pre_clear = 1'b1;
          end
        end
      end else if (hit_stat) begin
        s_d.dat = {24'h00_0000, status};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.cfg <= tpo_pkg::TPO_CFG_RESET;
      s_q.settle <= tpo_pkg::TPO_SETTLE_RESET;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign dat_o = s_q.dat;
  assign ack_o = s_q.ack;
  assign weak_pullup_disable_o = s_q.cfg[tpo_pkg::TPO_PULLUP_DIS_BIT];
  assign port_b_pullup_en_o = {8{~s_q.cfg[tpo_pkg::TPO_PULLUP_DIS_BIT]}};
  assign ext_int_event_o = s_q.int_evt;
  assign timer_inc_o = s_q.timer_inc;
  assign watchdog_tick_o = s_q.wdt_tick;
endmodule : tpo_option_ctl

// *** rtl/tpo_pkg.sv ***
// constants shared by the timer option configuration block
package tpo_pkg;
  // register indexes; byte address is four times the index
  localparam logic [11:0] TPO_CFG_IDX = 12'h181;
  localparam logic [11:0] TPO_STAT_IDX = 12'h182;
  localparam logic [7:0] TPO_CFG_RESET = 8'hff;
  // field positions in the option register
  localparam int TPO_PULLUP_DIS_BIT = 7;
  localparam int TPO_INT_EDGE_BIT = 6;
  localparam int TPO_CLK_SRC_BIT = 5;
  localparam int TPO_CLK_EDGE_BIT = 4;
  localparam int TPO_ASSIGN_BIT = 3;
  localparam int TPO_RATIO_LSB = 0;
  localparam int TPO_RATIO_W = 3;
  // field positions in the status register
  localparam int TPO_ST_TPIN_BIT = 0;
  localparam int TPO_ST_IPIN_BIT = 1;
  localparam int TPO_ST_ASSIGN_BIT = 2;
  // prescaler counter width and pin synchroniser depth
  localparam int TPO_PRE_W = 8;
  localparam int TPO_SYNC_STAGES = 3;
  localparam logic [7:0] TPO_PRE_RESET = 8'h00;
  // cycles after reset before pin edges count; covers filling the synchronisers
  localparam logic [2:0] TPO_SETTLE_RESET = 3'h5;
endpackage : tpo_pkg

// *** rtl/tpo_pin_sync.sv ***
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module tpo_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic [tpo_pkg::TPO_SYNC_STAGES-1:0] sh;
    logic level;
  } tpo_sync_s;

  tpo_sync_s s_q;
  tpo_sync_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[tpo_pkg::TPO_SYNC_STAGES-2:0], pin_i};
    // first stage is seen only by the second
    if (s_q.sh[1] == s_q.sh[2]) begin
      s_d.level = s_q.sh[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.level;
endmodule : tpo_pin_sync

// *** rtl/tpo_prescaler.sv ***
// shared power-of-two divider for timer or watchdog ticks
`timescale 1ns/1ps
module tpo_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [3:0] shift_i,
  output logic tick_o
);
  typedef struct packed {
    logic [tpo_pkg::TPO_PRE_W-1:0] cnt;
    logic out;
  } tpo_pre_s;

  tpo_pre_s p_q;
  tpo_pre_s p_d;
  logic [tpo_pkg::TPO_PRE_W:0] span;

  always_comb begin
    span = (9'h001 << shift_i) - 9'h001;
    p_d = p_q;
    p_d.out = 1'b0;
    if (clear_i) begin
      p_d.cnt = tpo_pkg::TPO_PRE_RESET;
    end else if (tick_i) begin
      if (p_q.cnt == span[tpo_pkg::TPO_PRE_W-1:0]) begin
        p_d.cnt = tpo_pkg::TPO_PRE_RESET;
        p_d.out = 1'b1;
      end else begin
        p_d.cnt = p_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_q <= '0;
    end else if (ce_i) begin
      p_q <= p_d;
    end
  end

  assign tick_o = p_q.out;
endmodule : tpo_prescaler

// *** test/tpo_pin_model.sv ***
// far-side pins: timer clock line and interrupt line
`timescale 1ns/1ps
module tpo_pin_model (
  input wire logic clk_i,
  input wire logic run_i,
  output logic tpin_o,
  output logic ipin_o
);
  // slow toggles, well past the input filter; still while idle
  logic [3:0] cnt_q = 4'h0;
  logic tpin_q = 1'b0;
  logic ipin_q = 1'b0;
  always @(posedge clk_i) begin
    if (run_i) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'hf) tpin_q <= ~tpin_q;
      if (cnt_q == 4'h7) ipin_q <= ~ipin_q;
    end
  end
  assign tpin_o = tpin_q;
  assign ipin_o = ipin_q;
endmodule : tpo_pin_model

// *** test/tpo_option_ctl_checker.sv ***
// assertions on the option control block ports
`timescale 1ns/1ps
module tpo_option_ctl_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic timer_ext_clock_pin_i,
  input wire logic ext_interrupt_pin_i,
  input wire logic [7:0] port_b_pullup_en_o,
  input wire logic weak_pullup_disable_o,
  input wire logic ext_int_event_o,
  input wire logic timer_inc_o
);
  localparam logic [31:0] A = {18'h0, tpo_pkg::TPO_CFG_IDX, 2'h0};
  logic [7:0] c_q;
  logic wr;
  // shadow follows the register at the edge a write is taken
  assign wr = ce_i && cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i == A;
  always_ff @(posedge clk_i) c_q <= rst_i ? tpo_pkg::TPO_CFG_RESET : wr ? dat_i[7:0] : c_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    ce_i && cyc_i && stb_i && !ack_o;
  endsequence
  sequence ext_inc_s;
    c_q[5] && c_q[3] ##1 timer_inc_o;
  endsequence
  AST_ACK: assert property (req_s |=> ack_o) else $error("ack timing");
  AST_ACKDROP: assert property (ack_o && ce_i |=> !ack_o) else $error("ack length");
  AST_RST: assert property ($fell(rst_i) |-> weak_pullup_disable_o) else $error("reset value");
  AST_PU: assert property (port_b_pullup_en_o == {8{!weak_pullup_disable_o}}) else $error("pullup");
  AST_WR: assert property (wr |=> weak_pullup_disable_o == $past(dat_i[7])) else $error("write");
  AST_RD: assert property (ack_o && !we_i && adr_i == A |-> dat_o[7:0] == c_q) else $error("read");
  AST_TPASS: assert property (c_q[5:3] == 3'h1 |=> timer_inc_o) else $error("timer pass");
  AST_TEXT: assert property (ext_inc_s |-> timer_ext_clock_pin_i == !$past(c_q[4])) else $error("pin edge");
  AST_INT: assert property (ext_int_event_o |-> ext_interrupt_pin_i == $past(c_q[6])) else $error("int edge");
endmodule : tpo_option_ctl_checker
bind tpo_option_ctl tpo_option_ctl_checker u_chk (.*);

// *** test/timer_prescale_option_ctl_tb.sv ***
// self-checking bench for the option control block
`timescale 1ns/1ps
module timer_prescale_option_ctl_tb;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, watchdog_tick_i = 0, run = 0;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, rd;
  logic ack_o, timer_ext_clock_pin_i, ext_interrupt_pin_i, weak_pullup_disable_o;
  logic ext_int_event_o, timer_inc_o, watchdog_tick_o;
  logic [7:0] port_b_pullup_en_o;
  int error_cnt = 0, compares = 0, cyc_n = 0, lat = 2, nt, ni, nw;
  // config byte, then expected ticks in 256 cycles
  logic [23:0] rows [16] = '{24'h000080, 24'h010040, 24'h020020, 24'h030010, 24'h040008, 24'h050004,
    24'h060002, 24'h070001, 24'h880100, 24'h890080, 24'h8a0040, 24'h8b0020, 24'h8c0010, 24'h8d0008,
    24'h8e0004, 24'h8f0002};
  tpo_option_ctl DUT (.*);
  tpo_pin_model u_pins (.clk_i, .run_i(run), .tpin_o(timer_ext_clock_pin_i), .ipin_o(ext_interrupt_pin_i));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    chk(t == lat, "ack latency");
  endtask : wb
  task automatic cnt(input int n);
    nt = 0;
    ni = 0;
    nw = 0;
    run <= 1;
    repeat (n) begin
      @(posedge clk_i);
      nt += timer_inc_o;
      ni += ext_int_event_o;
      nw += watchdog_tick_o;
    end
    run <= 0;
  endtask : cnt
  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 8000) begin
      chk(1'b0, "timeout");
      report_and_stop;
    end
  end
  initial begin
    int e;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 32'h604, 32'h0);
    chk(rd === 32'hff && port_b_pullup_en_o === 8'h0, "reset");
    watchdog_tick_i <= 1;
    // timer rows first; the move to the watchdog follows the 256-cycle count of the last timer row
    foreach (rows[i]) begin
      wb(1, 32'h604, {24'h0, rows[i][23:16]});
      wb(0, 32'h604, 32'h0);
      chk(rd[7:0] === rows[i][23:16] && port_b_pullup_en_o === {8{~rows[i][23]}}, "cfg");
      cnt(256);
      e = rows[i][19] ? nw : nt;
      chk(e <= rows[i][15:0] + 1 && e + 1 >= rows[i][15:0], "ratio");
      chk((rows[i][19] ? nt : nw) >= 255, "pass");
    end
    sel_i <= 4'h0;
    wb(1, 32'h604, 32'h0);
    sel_i <= 4'h1;
    wb(1, 32'h700, 32'h0);
    wb(0, 32'h700, 32'h0);
    chk(rd === 32'h0, "unmapped");
    wb(0, 32'h604, 32'h0);
    chk(rd === 32'h8f, "ignored");
    for (e = 0; e < 2; e++) begin
      wb(1, 32'h604, e ? 32'hf8 : 32'ha8);
      cnt(64);
      chk(nt > 0 && nt < 4 && ni > 0 && ni < 4, "pins");
    end
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 32'h604, 32'h0);
    chk(rd === 32'hff, "rereset");
    // let the synchronisers settle, then hold the bus frozen by the enable
    repeat (4) @(posedge clk_i);
    ce_i <= 0;
    lat = 4;
    fork
      wb(0, 32'h608, 32'h0);
      begin
        repeat (3) @(posedge clk_i);
        chk(ack_o === 1'b0, "frozen");
        ce_i <= 1;
      end
    join
    lat = 2;
    chk(rd === {29'h0, 1'b1, ext_interrupt_pin_i, timer_ext_clock_pin_i}, "status");
    report_and_stop;
  end
endmodule : timer_prescale_option_ctl_tb
